/* File: hw/sosc_consts.svh */
`ifndef SOSC_CONSTS_SVH
`define SOSC_CONSTS_SVH

// Number of reference outputs and their channel grouping.
`define SOSC_NUM_OUT 8
`define SOSC_CHAN_NUM 4

// Address fields: region picks the register kind, select picks the output.
`define SOSC_ADDR_REGION_HI 7
`define SOSC_ADDR_REGION_LO 5
`define SOSC_ADDR_SEL_HI 4
`define SOSC_ADDR_SEL_LO 2

// Register map, byte addresses on an 8-bit APB address.
`define SOSC_REGION_SRC 3'h0
`define SOSC_REGION_DRV 3'h1
`define SOSC_EN_ADDR 8'h40
`define SOSC_STAT_ADDR 8'h44
`define SOSC_BIAS_CFG_IDX 6'h19
`define SOSC_BIAS_CFG_ADDR {`SOSC_BIAS_CFG_IDX, 2'h0}

// Source and delay register fields.
`define SOSC_SRC_FINE_LO_HI 6
`define SOSC_SRC_FINE_LO_LO 5
`define SOSC_SRC_MUX 4
`define SOSC_SRC_COARSE_HI 3
`define SOSC_SRC_COARSE_LO 1
`define SOSC_SRC_FINE_HI 0
`define SOSC_SRC_MASK 8'h7F
`define SOSC_SRC_RST 8'h10
`define SOSC_SRC_MUX_RST 1'h1

// Driver state register fields.
`define SOSC_DRV_PD 7
`define SOSC_DRV_BIAS 5
`define SOSC_DRV_STYLE 4
`define SOSC_DRV_AMP_HI 3
`define SOSC_DRV_AMP_LO 2
`define SOSC_DRV_MASK 8'hBC
`define SOSC_DRV_RST 8'h00

// Enable register and global bias configuration.
`define SOSC_EN_RST 8'h00
`define SOSC_BIAS_TYPE_BIT 7
`define SOSC_BIAS_CFG_RST 1'h0

// Status register field positions.
`define SOSC_STAT_EN_LSB 0
`define SOSC_STAT_BIAS_LSB 8
`define SOSC_STAT_CHAN_LSB 16

`endif

/* File: hw/sosc_pkg.sv */
`default_nettype none

package sosc_pkg;

  // Control bundle driven to one output path.
  typedef struct packed {
    logic src_sel;
    logic [2:0] coarse_dly;
    logic [2:0] fine_dly;
    logic power_down;
    logic lvpecl;
    logic [1:0] amp;
    logic bias_on;
    logic drive_en;
  } sosc_path_t;

  // Output positions; channel A holds three, B and C two, D one.
  typedef enum logic [2:0] {
    SOSC_A0 = 3'h0,
    SOSC_A1 = 3'h1,
    SOSC_A2 = 3'h2,
    SOSC_B0 = 3'h3,
    SOSC_B1 = 3'h4,
    SOSC_C0 = 3'h5,
    SOSC_C1 = 3'h6,
    SOSC_D = 3'h7
  } sosc_out_idx_t;

endpackage : sosc_pkg

`default_nettype wire

/* File: hw/sosc_out_ctrl.sv */
`include "sosc_consts.svh"
`default_nettype none

module sosc_out_ctrl (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Settings of this output.
  input wire logic [7:0] src_reg,
  input wire logic [7:0] drv_reg,
  input wire logic enable,
  input wire logic bias_type,
  // Control to the output path.
  output sosc_pkg::sosc_path_t path
);

  sosc_pkg::sosc_path_t path_r;
  sosc_pkg::sosc_path_t path_nxt;
  logic pd;

  assign pd = drv_reg[`SOSC_DRV_PD];

  // Power-down overrides format, enable and amplitude, so those are forced quiet.
  assign path_nxt.src_sel = src_reg[`SOSC_SRC_MUX];
  assign path_nxt.coarse_dly = src_reg[`SOSC_SRC_COARSE_HI:`SOSC_SRC_COARSE_LO];
  assign path_nxt.fine_dly = {src_reg[`SOSC_SRC_FINE_HI],
                              src_reg[`SOSC_SRC_FINE_LO_HI:`SOSC_SRC_FINE_LO_LO]};
  assign path_nxt.power_down = pd;
  assign path_nxt.lvpecl = ~pd & drv_reg[`SOSC_DRV_STYLE];
  assign path_nxt.amp = pd ? 2'h0 : drv_reg[`SOSC_DRV_AMP_HI:`SOSC_DRV_AMP_LO];
  assign path_nxt.bias_on = ~pd & drv_reg[`SOSC_DRV_BIAS] & bias_type;
  assign path_nxt.drive_en = ~pd & enable;

  // Registering keeps the analog controls glitch free across a register write.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      path_r <= '{src_sel: `SOSC_SRC_MUX_RST, default: '0};
    end else begin
      path_r <= path_nxt;
    end
  end

  assign path = path_r;

endmodule : sosc_out_ctrl

`default_nettype wire

/* File: hw/sosc_top.sv */
// Functional notes
// - Eight identical output settings, channels A, B, C, D.
// - Source bit: 0 channel clock, 1 SYSREF; resets 1.
// - Coarse delay code times 169ps, resets 000.
// - Fine delay code 3 bits, split fields, resets 000.
// - Bias bit works only with global bias-type set.
// - Amplitude code 250mV to 1000mV, resets 00.
// - Power-down ignores format, enable and amplitude.
// - Format bit: 0 LVDS, 1 LVPECL; resets 0.
// - Enable 0 holds output low; resets 0.
`include "sosc_consts.svh"
`default_nettype none

module sosc_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Output path controls, one bundle per output.
  output sosc_pkg::sosc_path_t [`SOSC_NUM_OUT-1:0] ref_path,
  // Per channel flag: some output sends SYSREF.
  output logic [`SOSC_CHAN_NUM-1:0] chan_sysref_active
);

  // Storage for the per-output settings and the shared bits.
  logic [7:0] src_r [`SOSC_NUM_OUT];
  logic [7:0] drv_r [`SOSC_NUM_OUT];
  logic [7:0] en_r;
  logic [7:0] en_nxt;
  logic bias_type_r;
  logic bias_type_nxt;

  // Bus answer registers.
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // Decode wires.
  logic setup_ph;
  logic access_wr;
  logic lane0_wr;
  logic [2:0] region;
  logic [2:0] reg_sel;
  logic hit_src;
  logic hit_drv;
  logic hit_en;
  logic hit_stat;
  logic hit_bias;
  logic hit_any;

  // Readback of the live path state and of the selected per-output setting registers.
  logic [`SOSC_NUM_OUT-1:0] drive_vec;
  logic [`SOSC_NUM_OUT-1:0] bias_vec;
  logic [`SOSC_NUM_OUT-1:0] sysref_vec;
  logic [31:0] stat_word;
  logic [7:0] src_sel_word;
  logic [7:0] drv_sel_word;

  // Address decode; every register occupies one aligned word.
  assign region = paddr[`SOSC_ADDR_REGION_HI:`SOSC_ADDR_REGION_LO];
  assign reg_sel = paddr[`SOSC_ADDR_SEL_HI:`SOSC_ADDR_SEL_LO];
  assign hit_src = (region == `SOSC_REGION_SRC) && (paddr[1:0] == 2'h0);
  assign hit_drv = (region == `SOSC_REGION_DRV) && (paddr[1:0] == 2'h0);
  assign hit_en = (paddr == `SOSC_EN_ADDR);
  assign hit_stat = (paddr == `SOSC_STAT_ADDR);
  assign hit_bias = (paddr == `SOSC_BIAS_CFG_ADDR);
  assign hit_any = hit_src | hit_drv | hit_en | hit_stat | hit_bias;

  // Phases of a transfer; writes land only at the access edge.
  assign setup_ph = psel & ~penable;
  assign access_wr = psel & penable & pwrite & hit_any;
  assign lane0_wr = access_wr & pstrb[0];

  // The slave never stretches the access phase.
  assign pready = 1'h1;

  // Per-output setting registers; the bank is eight identical copies.
  for (genvar i = 0; i < `SOSC_NUM_OUT; i++) begin : g_out
    logic src_we;
    logic drv_we;

    assign src_we = lane0_wr & hit_src & (reg_sel == 3'(i));
    assign drv_we = lane0_wr & hit_drv & (reg_sel == 3'(i));

    // Reserved bits are masked so they always read back as zero.
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        src_r[i] <= `SOSC_SRC_RST;
      end else if (src_we) begin
        src_r[i] <= pwdata[7:0] & `SOSC_SRC_MASK;
      end
    end

    // Driver state resets powered up, LVDS, lowest amplitude, unbiased.
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        drv_r[i] <= `SOSC_DRV_RST;
      end else if (drv_we) begin
        drv_r[i] <= pwdata[7:0] & `SOSC_DRV_MASK;
      end
    end

    // Enable bits run from A0 in the top bit down to D in bit 0.
    sosc_out_ctrl u_ctrl (
      .core_clk (core_clk),
      .nrst (nrst),
      .src_reg (src_r[i]),
      .drv_reg (drv_r[i]),
      .enable (en_r[`SOSC_NUM_OUT-1-i]),
      .bias_type (bias_type_r),
      .path (ref_path[i])
    );

    assign drive_vec[i] = ref_path[i].drive_en;
    assign bias_vec[i] = ref_path[i].bias_on;
    assign sysref_vec[i] = ref_path[i].drive_en & ref_path[i].src_sel;
  end

  // Shared enable register and global bias-type bit.
  assign en_nxt = (lane0_wr & hit_en) ? pwdata[7:0] : en_r;
  assign bias_type_nxt = (lane0_wr & hit_bias) ? pwdata[`SOSC_BIAS_TYPE_BIT] : bias_type_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= `SOSC_EN_RST;
      bias_type_r <= `SOSC_BIAS_CFG_RST;
    end else begin
      en_r <= en_nxt;
      bias_type_r <= bias_type_nxt;
    end
  end

  // Channel flags follow the grouping A0..A2, B0..B1, C0..C1, D.
  assign chan_sysref_active[0] = sysref_vec[sosc_pkg::SOSC_A0] |
                                 sysref_vec[sosc_pkg::SOSC_A1] |
                                 sysref_vec[sosc_pkg::SOSC_A2];
  assign chan_sysref_active[1] = sysref_vec[sosc_pkg::SOSC_B0] |
                                 sysref_vec[sosc_pkg::SOSC_B1];
  assign chan_sysref_active[2] = sysref_vec[sosc_pkg::SOSC_C0] |
                                 sysref_vec[sosc_pkg::SOSC_C1];
  assign chan_sysref_active[3] = sysref_vec[sosc_pkg::SOSC_D];

  // Status word reflects what the paths are really doing, not the raw settings.
  assign stat_word = {12'h000, chan_sysref_active, bias_vec, drive_vec};

  // Selected per-output words for readback.
  assign src_sel_word = src_r[reg_sel];
  assign drv_sel_word = drv_r[reg_sel];

  // Read data is prepared in the setup cycle so it comes from a flip-flop
  // during the access cycle without costing a wait state.
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup_ph) begin
      pslverr_nxt = ~hit_any;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_src) begin
          prdata_nxt = {24'h00_0000, src_sel_word};
        end else if (hit_drv) begin
          prdata_nxt = {24'h00_0000, drv_sel_word};
        end else if (hit_en) begin
          prdata_nxt = {24'h00_0000, en_r};
        end else if (hit_stat) begin
          prdata_nxt = stat_word;
        end else if (hit_bias) begin
          prdata_nxt = {24'h00_0000, bias_type_r, 7'h00};
        end
      end
    end
  end

  // Bus answer flops.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'h0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Error shows only in the access phase so an idle bus sees it low.
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

endmodule : sosc_top

`default_nettype wire

/* File: tb/sosc_assertions.sv */
`include "sosc_consts.svh"
`default_nettype none

module sosc_assertions (
  // Clock, reset and bus.
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs under watch.
  input wire sosc_pkg::sosc_path_t [`SOSC_NUM_OUT-1:0] ref_path,
  input wire logic [`SOSC_CHAN_NUM-1:0] chan_sysref_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Access decode and a mirror of the global bias type, which gates every bias bit.
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && pstrb[0];
  logic bt_r;
  logic [7:0] on_w;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) bt_r <= 1'b0;
    else if (wr && paddr == 8'h64) bt_r <= pwdata[7];
  end

  sequence s_wr(logic [7:0] a);
    wr && paddr == a;
  endsequence
  property p_err;
    acc |-> pslverr == !(paddr[1:0] == 2'h0 && (paddr < 8'h48 || paddr == 8'h64));
  endproperty
  a_err: assert property (p_err) else $error("bus error flag wrong");
  property p_rdy;
    pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_chan;
    chan_sysref_active == {on_w[7], |on_w[6:5], |on_w[4:3], |on_w[2:0]};
  endproperty
  a_chan: assert property (p_chan) else $error("channel flags wrong");

  // Each output follows its own registers two edges after the write.
  for (genvar i = 0; i < `SOSC_NUM_OUT; i++) begin : g_out
    assign on_w[i] = ref_path[i].drive_en && ref_path[i].src_sel;
    property p_src;
      s_wr(8'(4 * i)) |-> ##2 ref_path[i].src_sel == $past(pwdata[4], 2);
    endproperty
    a_src: assert property (p_src) else $error("source select wrong");
    property p_dly;
      s_wr(8'(4 * i)) |-> ##2 {ref_path[i].coarse_dly, ref_path[i].fine_dly} ==
        {$past(pwdata[3:1], 2), $past(pwdata[0], 2), $past(pwdata[6:5], 2)};
    endproperty
    a_dly: assert property (p_dly) else $error("delay code wrong");
    property p_drv;
      s_wr(8'(32 + 4 * i)) ##0 !pwdata[7] |-> ##2
        {ref_path[i].lvpecl, ref_path[i].amp, ref_path[i].bias_on} ==
        {$past(pwdata[4:2], 2), $past(pwdata[5], 2) && $past(bt_r)};
    endproperty
    a_drv: assert property (p_drv) else $error("driver state wrong");
    property p_en;
      s_wr(8'h40) |-> ##2 ref_path[i].drive_en == ($past(pwdata[7 - i], 2) &&
        !ref_path[i].power_down);
    endproperty
    a_en: assert property (p_en) else $error("enable wrong");
    property p_pd;
      ref_path[i].power_down |-> {ref_path[i].lvpecl, ref_path[i].amp,
        ref_path[i].bias_on, ref_path[i].drive_en} == 5'h00;
    endproperty
    a_pd: assert property (p_pd) else $error("powered down output active");
  end
endmodule : sosc_assertions

bind sosc_top sosc_assertions sosc_assertions_i (.core_clk(core_clk), .nrst(nrst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .ref_path(ref_path),
  .chan_sysref_active(chan_sysref_active));

`default_nettype wire

/* File: tb/tb_top.sv */
`include "sosc_consts.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Bus, design outputs and the bench's own copy of the settings.
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sosc_pkg::sosc_path_t [7:0] ref_path;
  logic [3:0] chan_sysref_active;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] sreg [8];
  logic [7:0] dreg [8];
  logic [7:0] en;
  logic bt;

  sosc_top sosc_top_i (.core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_path(ref_path),
    .chan_sysref_active(chan_sysref_active));

  // A 50 ns clock.
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // The run needs a few hundred cycles, so a hang is cut off well beyond that.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end

  // One transfer; the request is held until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    chk(rdat, e);
    chk(32'(rerr), 32'(ee));
  endtask : rchk

  // Expected bundle; power-down silences format, amplitude, bias and enable.
  function automatic sosc_pkg::sosc_path_t mk(input logic [7:0] s, input logic [7:0] d,
    input logic e, input logic b);
    return '{s[4], s[3:1], {s[0], s[6:5]}, d[7], d[4] & ~d[7], d[3:2] & {2{~d[7]}},
      d[5] & b & ~d[7], e & ~d[7]};
  endfunction : mk

  // Compare all bundles, channel flags, status and read-back once writes have landed.
  task automatic pchk();
    sosc_pkg::sosc_path_t p;
    logic [7:0] de;
    logic [7:0] bo;
    logic [7:0] on;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      p = mk(sreg[i], dreg[i], en[7 - i], bt);
      de[i] = p.drive_en;
      bo[i] = p.bias_on;
      on[i] = p.drive_en & p.src_sel;
      chk(32'(ref_path[i]), 32'(p));
      rchk(8'(4 * i), 32'(sreg[i]), 1'b0);
      rchk(8'(32 + 4 * i), 32'(dreg[i]), 1'b0);
    end
    chk(32'(chan_sysref_active), 32'({on[7], |on[6:5], |on[4:3], |on[2:0]}));
    rchk(8'h44, {12'h0, on[7], |on[6:5], |on[4:3], |on[2:0], bo, de}, 1'b0);
    rchk(8'h40, 32'(en), 1'b0);
  endtask : pchk

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Reset values, then distinct settings per output, then refused accesses.
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sreg[i] = 8'h10;
      dreg[i] = 8'h00;
    end
    en = 8'h00;
    bt = 1'b0;
    pchk();
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      sreg[i] = {1'b0, ~i[1:0], i[0], i[2:0], ~i[2]};
      dreg[i] = {i == 6, 1'b0, ~i[2], i[2], i[1:0], 2'h0};
      apb(1'b1, 8'(4 * i), sreg[i] | 8'h80);
      apb(1'b1, 8'(32 + 4 * i), dreg[i] | 8'h43);
    end
    en = 8'hEF;
    apb(1'b1, 8'h40, en);
    pchk();
    bt = 1'b1;
    apb(1'b1, 8'h64, 8'h80);
    pchk();
    rchk(8'h64, 32'h80, 1'b0);
    $display("test settings done");
    apb(1'b1, 8'h44, 8'hFF);
    chk(32'(rerr), 32'h0);
    pstrb <= 4'hE;
    apb(1'b1, 8'h40, 8'h00);
    chk(32'(rerr), 32'h0);
    pstrb <= 4'hF;
    apb(1'b1, 8'h48, 8'hFF);
    chk(32'(rerr), 32'h1);
    rchk(8'h48, 32'h0, 1'b1);
    rchk(8'h02, 32'h0, 1'b1);
    rchk(8'hFC, 32'h0, 1'b1);
    pchk();
    $display("test refusals done");
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
